// ==== design/pcs_rx_regs.v ====
// Register slice of the SGMII PCS receive side: state code and controls.
// Assumes a classic Wishbone master on clk_i and datapath signals that
// are already synchronous to clk_i.
//
// Contract
// - Receive state code readable, bits 4:0, read-only
// - Codes 0-3: reset, link fail, comma wait/seen
// - Codes 4-6: three configuration reception states
// - Codes 7-9: invalid, idle, false carrier
// - Codes 10-12: packet begin, early end, termination
// - Codes 13-15: extended terminations, burst receive
// - Codes 16-18: extend error, data error, data
// - Configuration bit 3 enables real-time Ethernet
// - Configuration bit 2 holds transmit path reset
// - Configuration bit 1 holds receive path reset
// - Configuration bit 0 loops receive into transmit
// - Buffer control bit 1 holds buffer initialized
// - Buffer disable waits for current transfer end
// - Buffer enable drives the buffer clock gate
`timescale 1ns/1ns
`include "pcs_rx_defines.vh"

module pcs_rx_regs #(
	parameter ADR_W = 18
) (
	input wire clk_i,
	input wire rst_i,
	// Wishbone classic slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [ADR_W-1:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output wire [31:0] dat_o,
	output wire ack_o,
	// Receive datapath status
	input wire [4:0] rx_state_i,
	input wire rxb_busy_i,
	// Controls towards the PCS datapath
	output wire realtime_ethernet_enable_o,
	output wire transmit_path_reset_o,
	output wire receive_path_reset_o,
	output wire rx_to_tx_loopback_o,
	output wire receive_buffer_init_o,
	output wire receive_buffer_clock_en_o
);

	// Only codes the receive machine can take are reported
	function code_legal;
		input [4:0] code;
		begin
			case (code)
				`ST_RESET,
				`ST_LINK_FAILED,
				`ST_WAIT_COMMA,
				`ST_COMMA_SEEN,
				`ST_CONFIG_FIRST,
				`ST_CONFIG_SECOND,
				`ST_CONFIG_THIRD,
				`ST_DATA_INVALID,
				`ST_IDLE,
				`ST_FALSE_CARRIER,
				`ST_PACKET_BEGIN,
				`ST_EARLY_END,
				`ST_CLEAN_TERMINATION,
				`ST_TERMINATION_EXTENDED,
				`ST_TERMINATION_EXTENDED_ALT,
				`ST_BURST_RECEIVE,
				`ST_EXTEND_ERROR,
				`ST_DATA_ERROR,
				`ST_DATA_RECEIVE: begin
					code_legal = 1'b1;
				end
				default: begin
					code_legal = 1'b0;
				end
			endcase
		end
	endfunction

	// Merge a written word into a register by byte lane and field mask
	function [15:0] lane_merge;
		input [15:0] old_val;
		input [15:0] new_val;
		input [1:0] sel;
		input [15:0] mask;
		reg [15:0] lanes;
		begin
			lanes = {{8{sel[1]}}, {8{sel[0]}}} & mask;
			lane_merge = (old_val & ~lanes) | (new_val & lanes);
		end
	endfunction

	wire [`REG_IDX_W-1:0] idx;
	wire req;
	wire hit_state;
	wire hit_cfg;
	wire hit_rxb;
	wire wr_cfg;
	wire wr_rxb;
	wire gate_en;

	reg ack_q;
	reg [31:0] dat_q;
	reg [31:0] dat_d;
	reg [15:0] cfg_q;
	reg [15:0] rxb_ctl_q;
	reg [4:0] state_code_q;
	reg realtime_q;
	reg tx_reset_q;
	reg rx_reset_q;
	reg loopback_q;
	reg rxb_init_q;

	// Word index; the two low address bits select bytes, not registers
	assign idx = adr_i[`REG_IDX_W+1:2];
	// A new request is taken only while no answer is pending
	assign req = cyc_i & stb_i & ~ack_q;
	assign hit_state = (idx == `IDX_RECEIVE_FSM_STATE);
	assign hit_cfg = (idx == `IDX_PCS_CONFIGURATION);
	assign hit_rxb = (idx == `IDX_RECEIVE_BUFFER_CONTROL);
	// Writes to the state register are dropped, it is hardware owned
	assign wr_cfg = req & we_i & hit_cfg;
	assign wr_rxb = req & we_i & hit_rxb;

	// Single-cycle answer, dropped the cycle after it was given
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// Configuration register, reserved bits masked off
	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q <= `RST_PCS_CONFIGURATION;
		end else if (wr_cfg) begin
			cfg_q <= lane_merge(cfg_q, dat_i[15:0], sel_i[1:0],
				`MASK_PCS_CONFIGURATION);
		end
	end

	// Buffer control register; enable comes up set after reset
	always @(posedge clk_i) begin
		if (rst_i) begin
			rxb_ctl_q <= `RST_RECEIVE_BUFFER_CONTROL;
		end else if (wr_rxb) begin
			rxb_ctl_q <= lane_merge(rxb_ctl_q, dat_i[15:0], sel_i[1:0],
				`MASK_RECEIVE_BUFFER_CONTROL);
		end
	end

	// Receive state capture. While the receive path is held in reset
	// the machine is in its reset state, so report that directly. An
	// illegal code from the datapath leaves the last good one standing,
	// which hides glitches at the cost of hiding a broken machine.
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_code_q <= `ST_RESET;
		end else if (rx_reset_q) begin
			state_code_q <= `ST_RESET;
		end else if (code_legal(rx_state_i)) begin
			state_code_q <= rx_state_i;
		end
	end

	// Control outputs registered from the fields
	always @(posedge clk_i) begin
		if (rst_i) begin
			realtime_q <= 1'b0;
			tx_reset_q <= 1'b0;
			rx_reset_q <= 1'b0;
			loopback_q <= 1'b0;
			rxb_init_q <= 1'b0;
		end else begin
			realtime_q <= cfg_q[`BIT_REALTIME_ETHERNET_ENABLE];
			tx_reset_q <= cfg_q[`BIT_TRANSMIT_PATH_RESET];
			rx_reset_q <= cfg_q[`BIT_RECEIVE_PATH_RESET];
			loopback_q <= cfg_q[`BIT_RX_TO_TX_LOOPBACK];
			rxb_init_q <= rxb_ctl_q[`BIT_RECEIVE_BUFFER_INIT];
		end
	end

	// Read mux; unmapped addresses answer with zero
	always @* begin
		dat_d = 32'h00000000;
		if (hit_state) begin
			dat_d[`STATE_CODE_MSB:0] = state_code_q;
		end else if (hit_cfg) begin
			dat_d[15:0] = cfg_q & `MASK_PCS_CONFIGURATION;
		end else if (hit_rxb) begin
			dat_d[15:0] = rxb_ctl_q & `MASK_RECEIVE_BUFFER_CONTROL;
		end
	end

	// Read data sampled with a read request, held until the next read
	always @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h00000000;
		end else if (req && !we_i) begin
			dat_q <= dat_d;
		end
	end

	// Clock gate follows the enable but lets a transfer finish
	rxb_clock_gate_ctrl u_gate (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_req_i(rxb_ctl_q[`BIT_RECEIVE_BUFFER_ENABLE]),
		.busy_i(rxb_busy_i),
		.gate_en_o(gate_en),
		.draining_o()
	);

	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign realtime_ethernet_enable_o = realtime_q;
	assign transmit_path_reset_o = tx_reset_q;
	assign receive_path_reset_o = rx_reset_q;
	assign rx_to_tx_loopback_o = loopback_q;
	assign receive_buffer_init_o = rxb_init_q;
	assign receive_buffer_clock_en_o = gate_en;

endmodule // pcs_rx_regs

// ==== design/rxb_clock_gate_ctrl.v ====
// Receive buffer clock gate controller.
// Assumes busy_i comes from datapath logic on the same clock.
`timescale 1ns/1ns
`include "pcs_rx_defines.vh"

module rxb_clock_gate_ctrl (
	input wire clk_i,
	input wire rst_i,
	input wire enable_req_i,
	input wire busy_i,
	output wire gate_en_o,
	output wire draining_o
);

	localparam [1:0] S_ON = 2'b00;
	localparam [1:0] S_DRAIN = 2'b01;
	localparam [1:0] S_OFF = 2'b10;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg gate_en_q;

	// Next state; a transfer in flight keeps the clock running
	always @* begin
		state_d = state_q;
		case (state_q)
			S_ON: begin
				if (!enable_req_i) begin
					state_d = busy_i ? S_DRAIN : S_OFF;
				end
			end
			S_DRAIN: begin
				if (enable_req_i) begin
					state_d = S_ON;
				end else if (!busy_i) begin
					state_d = S_OFF;
				end
			end
			S_OFF: begin
				if (enable_req_i) begin
					state_d = S_ON;
				end
			end
			default: begin
				state_d = S_ON;
			end
		endcase
	end

	// Gate enable registered so the gating cell sees a clean level
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= S_ON;
			gate_en_q <= 1'b1;
		end else begin
			state_q <= state_d;
			gate_en_q <= (state_d != S_OFF);
		end
	end

	assign gate_en_o = gate_en_q;
	assign draining_o = (state_q == S_DRAIN);

endmodule // rxb_clock_gate_ctrl

// ==== shared/pcs_rx_defines.vh ====
// Register map, field positions and state codes of the PCS receive slice.
// Included by the register bank and its buffer clock gate controller.
`ifndef PCS_RX_DEFINES_VH
`define PCS_RX_DEFINES_VH

// Register indices; the byte address on the bus is four times the index
`define REG_IDX_W 16
`define IDX_RECEIVE_FSM_STATE 16'hD30E
`define IDX_PCS_CONFIGURATION 16'hD400
`define IDX_RECEIVE_BUFFER_CONTROL 16'hD401

// Reset values
`define RST_RECEIVE_FSM_STATE 16'h0000
`define RST_PCS_CONFIGURATION 16'h0000
`define RST_RECEIVE_BUFFER_CONTROL 16'h0001

// Field positions and widths
`define STATE_CODE_W 5
`define STATE_CODE_MSB 4
`define BIT_REALTIME_ETHERNET_ENABLE 3
`define BIT_TRANSMIT_PATH_RESET 2
`define BIT_RECEIVE_PATH_RESET 1
`define BIT_RX_TO_TX_LOOPBACK 0
`define BIT_RECEIVE_BUFFER_INIT 1
`define BIT_RECEIVE_BUFFER_ENABLE 0

// Writable bit masks; everything else is reserved and reads zero
`define MASK_PCS_CONFIGURATION 16'h000F
`define MASK_RECEIVE_BUFFER_CONTROL 16'h0003

// Receive state machine codes
`define ST_RESET 5'h00
`define ST_LINK_FAILED 5'h01
`define ST_WAIT_COMMA 5'h02
`define ST_COMMA_SEEN 5'h03
`define ST_CONFIG_FIRST 5'h04
`define ST_CONFIG_SECOND 5'h05
`define ST_CONFIG_THIRD 5'h06
`define ST_DATA_INVALID 5'h07
`define ST_IDLE 5'h08
`define ST_FALSE_CARRIER 5'h09
`define ST_PACKET_BEGIN 5'h0A
`define ST_EARLY_END 5'h0B
`define ST_CLEAN_TERMINATION 5'h0C
`define ST_TERMINATION_EXTENDED 5'h0D
`define ST_TERMINATION_EXTENDED_ALT 5'h0E
`define ST_BURST_RECEIVE 5'h0F
`define ST_EXTEND_ERROR 5'h10
`define ST_DATA_ERROR 5'h11
`define ST_DATA_RECEIVE 5'h12

`endif

// ==== testbench/pcs_rx_regs_properties.sv ====
// Checker for the PCS receive register slice, bound to pcs_rx_regs.
// Assumes a classic Wishbone master that holds each request until ack.
`timescale 1ns/1ns
module pcs_rx_regs_properties #(
	parameter ADR_W = 18
) (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [ADR_W-1:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	input wire [31:0] dat_o,
	input wire ack_o,
	input wire [4:0] rx_state_i,
	input wire rxb_busy_i,
	input wire realtime_ethernet_enable_o,
	input wire transmit_path_reset_o,
	input wire receive_path_reset_o,
	input wire rx_to_tx_loopback_o,
	input wire receive_buffer_init_o,
	input wire receive_buffer_clock_en_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Requests as the slave takes them
	wire take = cyc_i && stb_i && !ack_o;
	wire wr_cfg = take && we_i && sel_i[0] && adr_i == 18'h35000;
	wire wr_rxb = take && we_i && sel_i[0] && adr_i == 18'h35004;
	wire rd_st = take && !we_i && adr_i == 18'h34C38;
	wire rd_none = take && !we_i && adr_i == 18'h00000;
	// Disable while idle: the gate must close without waiting
	sequence s_clr; wr_rxb && !dat_i[0]; endsequence
	sequence s_idle; !rxb_busy_i [*3]; endsequence
	property p_ack; take |=> ack_o ##1 !ack_o; endproperty
	a_ack: assert property (p_ack) else $error("bad ack");
	property p_st; rd_st && $stable(rx_state_i) && rx_state_i <= 5'h12
		&& !receive_path_reset_o |=> dat_o == {27'h0, $past(rx_state_i)};
	endproperty
	a_st: assert property (p_st) else $error("bad state");
	property p_rxr; rd_st && receive_path_reset_o |=> dat_o == 32'h0;
	endproperty
	a_rxr: assert property (p_rxr) else $error("bad rx reset");
	property p_cfg; wr_cfg |-> ##2 {realtime_ethernet_enable_o,
		transmit_path_reset_o, receive_path_reset_o, rx_to_tx_loopback_o}
		== $past(dat_i[3:0], 2);
	endproperty
	a_cfg: assert property (p_cfg) else $error("bad cfg");
	property p_init; wr_rxb |-> ##2 receive_buffer_init_o == $past(dat_i[1], 2);
	endproperty
	a_init: assert property (p_init) else $error("bad init");
	property p_off; s_clr ##1 s_idle |-> !receive_buffer_clock_en_o;
	endproperty
	a_off: assert property (p_off) else $error("gate open");
	property p_busy;
		receive_buffer_clock_en_o && rxb_busy_i |=> receive_buffer_clock_en_o;
	endproperty
	a_busy: assert property (p_busy) else $error("cut transfer");
	property p_on; wr_rxb && dat_i[0] |-> ##[1:3] receive_buffer_clock_en_o;
	endproperty
	a_on: assert property (p_on) else $error("gate shut");
	property p_none; rd_none |=> dat_o == 32'h0; endproperty
	a_none: assert property (p_none) else $error("bad unmapped");
endmodule // pcs_rx_regs_properties

bind pcs_rx_regs pcs_rx_regs_properties #(.ADR_W(ADR_W)) prop_u (.clk_i,
	.rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
	.rx_state_i, .rxb_busy_i, .realtime_ethernet_enable_o,
	.transmit_path_reset_o, .receive_path_reset_o, .rx_to_tx_loopback_o,
	.receive_buffer_init_o, .receive_buffer_clock_en_o);

// ==== testbench/pcs_rx_regs_tb.sv ====
// Self-checking bench for the PCS receive register slice.
// Assumes the design answers each Wishbone request with one ack pulse.
`timescale 1ns/1ns
module pcs_rx_regs_tb;
	localparam logic [17:0] A_ST = 18'h34C38;
	localparam logic [17:0] A_CFG = 18'h35000;
	localparam logic [17:0] A_RXB = 18'h35004;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic busy = 1'b0;
	logic [17:0] adr_i = 18'h00000;
	logic [31:0] dat_i = 32'h0;
	logic [4:0] code = 5'h00;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic ack_o, rte, txr, rxr, rx_to_tx_loopback, binit, ben;
	int n_mismatch = 0;
	int comparisons = 0;
	always #4 clk_i = ~clk_i;
	pcs_rx_regs #(.ADR_W(18)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(4'h3), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.rx_state_i(code), .rxb_busy_i(busy),
		.realtime_ethernet_enable_o(rte), .transmit_path_reset_o(txr),
		.receive_path_reset_o(rxr), .rx_to_tx_loopback_o(rx_to_tx_loopback),
		.receive_buffer_init_o(binit), .receive_buffer_clock_en_o(ben));
	task close_out;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	// One classic cycle; a missing ack ends the run
	task xfer(input logic w, input logic [17:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1) begin
			n_mismatch++;
			close_out();
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	initial begin
		tick(12);
		rst_i <= 1'b0;
		xfer(1'b0, A_CFG, 32'h0);
		check(rd, 32'h0);
		xfer(1'b0, A_RXB, 32'h0);
		check(rd, 32'h1);
		// All legal codes, then an illegal one that must not show
		for (int c = 0; c < 20; c++) begin
			code <= c[4:0];
			tick(2);
			xfer(1'b0, A_ST, 32'h0);
			check(rd, c < 19 ? 32'(c) : 32'h12);
		end
		xfer(1'b1, A_ST, 32'h1F);
		xfer(1'b0, A_ST, 32'h0);
		check(rd, 32'h12);
		// Each control bit alone, reserved bits set as well
		for (int b = 0; b < 4; b++) begin
			xfer(1'b1, A_CFG, 32'hFFF0 | (32'h1 << b));
			tick(2);
			xfer(1'b0, A_CFG, 32'h0);
			check(rd, 32'h1 << b);
			check({28'h0, rte, txr, rxr, rx_to_tx_loopback}, 32'h1 << b);
		end
		code <= 5'h05;
		xfer(1'b1, A_CFG, 32'h2);
		tick(2);
		xfer(1'b0, A_ST, 32'h0);
		check(rd, 32'h0);
		xfer(1'b1, A_CFG, 32'h0);
		xfer(1'b1, A_RXB, 32'hFFFF);
		tick(2);
		xfer(1'b0, A_RXB, 32'h0);
		check(rd, 32'h3);
		check({31'h0, binit}, 32'h1);
		// Disable in mid-transfer: the clock must keep running
		busy <= 1'b1;
		xfer(1'b1, A_RXB, 32'h0);
		tick(5);
		check({31'h0, ben}, 32'h1);
		busy <= 1'b0;
		tick(3);
		check({31'h0, ben}, 32'h0);
		xfer(1'b1, A_RXB, 32'h1);
		tick(3);
		check({31'h0, ben}, 32'h1);
		xfer(1'b1, A_RXB, 32'h0);
		tick(4);
		check({31'h0, ben}, 32'h0);
		xfer(1'b1, 18'h0, 32'hFFFF);
		xfer(1'b0, 18'h0, 32'h0);
		check(rd, 32'h0);
		close_out();
	end
endmodule // pcs_rx_regs_tb
